// >>> nis_pkg.sv
// Overview of operation
// - Writing one clears that cause flag
// - Interrupt line high while unmasked flag set
// - Each flag gated by its own mask
// - Bit 0 set on clean frame reception
// - Bit 1 set on clean frame transmission
// - Bit 2 set on any receive fault
// - Bit 3 set on any transmit fault
// - Bit 4 set when receive ring exhausted
// - Bit 5 set on tally counter MSB
// - Bit 6 set when host copy completes
// - Bit 7 follows offline, cleared by go
// - Bit 7 also flags ring overflow
// - Cause register writes never change bit 7
// - Bit 7 never raises the interrupt
// - Mask bits 0 to 6 enable flags
// - Mask bank powers up cleared
// - Stop goes offline after frame finishes

package nis_pkg;

   // ------------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ------------------------------------------------------------------
   localparam logic [5:0] NIS_CMD_IDX   = 6'h00;
   localparam logic [5:0] NIS_CAUSE_IDX = 6'h07;
   localparam logic [5:0] NIS_MASK_IDX  = 6'h0f;
   localparam int         NIS_AW        = 8;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int         NIS_CMD_STOP_BIT = 0;
   localparam int         NIS_CMD_GO_BIT   = 1;
   localparam int         NIS_NFLAGS       = 7;
   localparam logic [1:0] NIS_CMD_RST      = 2'h1;
   localparam logic [6:0] NIS_MASK_RST     = 7'h00;
   localparam logic [6:0] NIS_FLAGS_RST    = 7'h00;
   localparam int         NIS_TALLY_N      = 3;

   // ------------------------------------------------------------------
   // Bus response codes
   // ------------------------------------------------------------------
   localparam logic [1:0] NIS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] NIS_RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // Event carrier from the datapath, one-cycle pulses except tally
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                   frame_received_ok;
      logic                   frame_sent_ok;
      logic                   rx_crc_err;
      logic                   rx_align_err;
      logic                   rx_fifo_overrun;
      logic                   rx_missed;
      logic                   tx_excess_coll;
      logic                   tx_fifo_underrun;
      logic                   ring_overrun_warning;
      logic [NIS_TALLY_N-1:0] tally_msb;
      logic                   host_copy_done;
      logic                   ring_overflow;
      logic                   frame_removed;
   } nis_ev_t;

endpackage

// >>> nis_event_map.sv
`timescale 1ns/1ps
`default_nettype none

module nis_event_map (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire nis_pkg::nis_ev_t ev,
   output logic [6:0]          set_vec
);

   typedef struct packed {
      logic [nis_pkg::NIS_TALLY_N-1:0] msb_prev;
   } nis_map_st_t;

   nis_map_st_t state_ff;
   nis_map_st_t nxt_state;
   logic        tally_rise;

   // ------------------------------------------------------------------
   // Event to flag mapping
   // ------------------------------------------------------------------
   // Tally MSB is a level; only its rising edge counts as an event
   always_comb begin
      nxt_state.msb_prev = ev.tally_msb;
      tally_rise = |(ev.tally_msb & ~state_ff.msb_prev);
      set_vec[0] = ev.frame_received_ok;
      set_vec[1] = ev.frame_sent_ok;
      set_vec[2] = ev.rx_crc_err | ev.rx_align_err |
                   ev.rx_fifo_overrun | ev.rx_missed;
      set_vec[3] = ev.tx_excess_coll | ev.tx_fifo_underrun;
      set_vec[4] = ev.ring_overrun_warning;
      set_vec[5] = tally_rise;
      set_vec[6] = ev.host_copy_done;
   end

   // Counters already past MSB at reset release do not fire
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff.msb_prev <= '1;
      end else begin
         state_ff <= nxt_state;
      end
   end

endmodule
`default_nettype wire

// >>> nis_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module nis_top (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic [2:0]       s_axi_awprot,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic [2:0]       s_axi_arprot,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire nis_pkg::nis_ev_t ev,
   input  wire logic             frame_busy,
   output logic                  irq,
   output logic                  controller_offline
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                        awready;
      logic                        wready;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        arready;
      logic                        rvalid;
      logic [1:0]                  rresp;
      logic [31:0]                 rdata;
      logic                        aw_got;
      logic                        w_got;
      logic [nis_pkg::NIS_AW-1:0]  aw_addr;
      logic [7:0]                  w_data;
      logic                        w_lane0;
      logic [6:0]                  flags;
      logic [6:0]                  mask;
      logic [1:0]                  cmd;
      logic                        offline;
      logic                        ring_ovf;
      logic                        irq;
   } nis_top_st_t;

   nis_top_st_t state_ff;
   nis_top_st_t nxt_state;
   logic [6:0]  set_vec;
   logic [6:0]  wr_clr;
   logic        wr_cause;
   logic        go_wr;
   logic        enter_off;
   logic        aw_fire;
   logic        w_fire;
   logic        do_wr;
   logic [nis_pkg::NIS_AW-1:0] wr_addr;
   logic [7:0]  wr_data;
   logic        wr_lane0;

   // Register index of a byte address, or all ones when unmapped
   function automatic logic [5:0] reg_index(
      input logic [nis_pkg::NIS_AW-1:0] addr
   );
      logic [5:0] idx;
      idx = addr[7:2];
      if (idx == nis_pkg::NIS_CMD_IDX || idx == nis_pkg::NIS_CAUSE_IDX ||
          idx == nis_pkg::NIS_MASK_IDX) begin
         return idx;
      end
      return 6'h3f;
   endfunction

   nis_event_map u_map (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ev      (ev),
      .set_vec (set_vec)
   );

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   // Address and data may arrive in either order; the write is applied
   // only once both are held and no response is pending
   always_comb begin
      nxt_state = state_ff;
      wr_clr    = 7'h00;
      wr_cause  = 1'b0;
      go_wr     = 1'b0;
      enter_off = 1'b0;
      aw_fire   = s_axi_awvalid & state_ff.awready;
      w_fire    = s_axi_wvalid & state_ff.wready;
      wr_addr   = aw_fire ? s_axi_awaddr : state_ff.aw_addr;
      wr_data   = w_fire ? s_axi_wdata[7:0] : state_ff.w_data;
      wr_lane0  = w_fire ? s_axi_wstrb[0] : state_ff.w_lane0;
      do_wr     = (state_ff.aw_got | aw_fire) &
                  (state_ff.w_got | w_fire) & ~state_ff.bvalid;

      // Write channel
      if (state_ff.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end
      if (aw_fire) begin
         nxt_state.aw_got  = 1'b1;
         nxt_state.aw_addr = s_axi_awaddr;
      end
      if (w_fire) begin
         nxt_state.w_got   = 1'b1;
         nxt_state.w_data  = s_axi_wdata[7:0];
         nxt_state.w_lane0 = s_axi_wstrb[0];
      end
      if (do_wr) begin
         nxt_state.aw_got = 1'b0;
         nxt_state.w_got  = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp  = nis_pkg::NIS_RESP_OKAY;
         case (reg_index(wr_addr))
            nis_pkg::NIS_CMD_IDX: begin
               if (wr_lane0) begin
                  nxt_state.cmd = wr_data[1:0];
                  go_wr = wr_data[nis_pkg::NIS_CMD_GO_BIT] &
                          ~wr_data[nis_pkg::NIS_CMD_STOP_BIT];
               end
            end
            nis_pkg::NIS_CAUSE_IDX: begin
               wr_cause = wr_lane0;
               // Bit 7 is not writable, only flags 0..6 clear
               if (wr_lane0) begin
                  wr_clr = wr_data[6:0];
               end
            end
            nis_pkg::NIS_MASK_IDX: begin
               if (wr_lane0) begin
                  nxt_state.mask = wr_data[6:0];
               end
            end
            default: begin
               nxt_state.bresp = nis_pkg::NIS_RESP_SLVERR;
            end
         endcase
      end
      nxt_state.awready = ~nxt_state.aw_got;
      nxt_state.wready  = ~nxt_state.w_got;

      // Read channel, reads have no side effects
      if (state_ff.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state_ff.arready) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rresp  = nis_pkg::NIS_RESP_OKAY;
         case (reg_index(s_axi_araddr))
            nis_pkg::NIS_CMD_IDX: begin
               nxt_state.rdata = {30'h0, state_ff.cmd};
            end
            nis_pkg::NIS_CAUSE_IDX: begin
               nxt_state.rdata = {24'h0, state_ff.offline |
                                  state_ff.ring_ovf, state_ff.flags};
            end
            nis_pkg::NIS_MASK_IDX: begin
               nxt_state.rdata = {25'h0, state_ff.mask};
            end
            default: begin
               nxt_state.rdata = 32'h0;
               nxt_state.rresp = nis_pkg::NIS_RESP_SLVERR;
            end
         endcase
      end
      nxt_state.arready = ~nxt_state.rvalid;

      // Flags: a new event beats a clear in the same cycle
      nxt_state.flags = (state_ff.flags & ~wr_clr) | set_vec;

      // Offline waits for the frame in progress; go leaves it
      if (go_wr) begin
         nxt_state.offline = 1'b0;
      end else if (nxt_state.cmd[nis_pkg::NIS_CMD_STOP_BIT] && !frame_busy) begin
         enter_off = ~state_ff.offline;
         nxt_state.offline = 1'b1;
      end

      // Overflow status set wins over frame removal
      if (ev.ring_overflow) begin
         nxt_state.ring_ovf = 1'b1;
      end else if (ev.frame_removed) begin
         nxt_state.ring_ovf = 1'b0;
      end

      // Only flags 0..6 reach the line; bit 7 is status only
      nxt_state.irq = |(nxt_state.flags & nxt_state.mask);
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   // Flags reset to zero; software still clears them as a habit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff         <= '0;
         state_ff.flags   <= nis_pkg::NIS_FLAGS_RST;
         state_ff.mask    <= nis_pkg::NIS_MASK_RST;
         state_ff.cmd     <= nis_pkg::NIS_CMD_RST;
         state_ff.offline <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready      = state_ff.awready;
   assign s_axi_wready       = state_ff.wready;
   assign s_axi_bvalid       = state_ff.bvalid;
   assign s_axi_bresp        = state_ff.bresp;
   assign s_axi_arready      = state_ff.arready;
   assign s_axi_rvalid       = state_ff.rvalid;
   assign s_axi_rresp        = state_ff.rresp;
   assign s_axi_rdata        = state_ff.rdata;
   assign irq                = state_ff.irq;
   assign controller_offline = state_ff.offline;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_cause_clear;
      (|wr_clr);
   endsequence

   sequence s_bit7_write_quiet;
      wr_cause && wr_data[7] && !state_ff.offline && !state_ff.ring_ovf &&
      !ev.ring_overflow && !enter_off;
   endsequence

   property p_clear;
      s_cause_clear |=>
         ((state_ff.flags & $past(wr_clr) & ~$past(set_vec)) == 7'h00);
   endproperty
   a_clear: assert property (p_clear)
      else $error("written one did not clear flag");

   property p_hold;
      ##1 (($past(state_ff.flags) & ~$past(wr_clr) & ~state_ff.flags)
           == 7'h00);
   endproperty
   a_hold: assert property (p_hold)
      else $error("flag dropped without a clear");

   property p_set_wins;
      (|set_vec) |=> (($past(set_vec) & ~state_ff.flags) == 7'h00);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost against clear");

   property p_ev_rx;
      (ev.rx_crc_err || ev.rx_missed) |=> state_ff.flags[2];
   endproperty
   a_ev_rx: assert property (p_ev_rx)
      else $error("receive fault not flagged");

   property p_ev_ok;
      (ev.frame_received_ok || ev.frame_sent_ok) |=>
         ((~state_ff.flags[1:0] & {$past(ev.frame_sent_ok),
                                   $past(ev.frame_received_ok)}) == 2'h0);
   endproperty
   a_ev_ok: assert property (p_ev_ok)
      else $error("good frame not flagged");

   property p_irq;
      state_ff.irq == |(state_ff.flags & state_ff.mask);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt line disagrees with flags and mask");

   property p_status_silent;
      (state_ff.offline && ((state_ff.flags & state_ff.mask) == 7'h00))
         |-> !irq;
   endproperty
   a_status_silent: assert property (p_status_silent)
      else $error("status bit raised interrupt");

   property p_mask_reset;
      $rose(aresetn) |-> (state_ff.mask == 7'h00) && !irq;
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("mask not cleared at reset");

   property p_bit7_ro;
      s_bit7_write_quiet |=> !(state_ff.offline | state_ff.ring_ovf);
   endproperty
   a_bit7_ro: assert property (p_bit7_ro)
      else $error("host write changed bit 7");

   property p_stop;
      (state_ff.cmd[0] && !frame_busy && !go_wr) |=> state_ff.offline;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not go offline");

   property p_go;
      go_wr |=> !state_ff.offline;
   endproperty
   a_go: assert property (p_go)
      else $error("go did not leave offline");

   // Mask writes land whole; data bit 7 has no mask behind it
   property p_mask_wr;
      (do_wr && wr_lane0 && reg_index(wr_addr) == nis_pkg::NIS_MASK_IDX)
         |=> (state_ff.mask == 7'($past(wr_data)));
   endproperty
   a_mask_wr: assert property (p_mask_wr)
      else $error("mask write not applied");

   // A frame on the wire keeps the controller online until it ends
   property p_busy_wait;
      (frame_busy && !state_ff.offline && !go_wr) |=> !state_ff.offline;
   endproperty
   a_busy_wait: assert property (p_busy_wait)
      else $error("went offline during a frame");

   property p_ovf;
      (ev.ring_overflow || ev.frame_removed) |=>
         (state_ff.ring_ovf == $past(ev.ring_overflow));
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("ring overflow not shown");

endmodule
`default_nettype wire

// >>> nis_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host processor model, one read and one write at a time
// ----------------------------------------------------------------
module nis_host_model (
   input  wire logic        aclk,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid
);
   // Idle bus at time zero
   initial begin
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wstrb = '0;
      wvalid = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
   end

   // Released payload is inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      logic done;
      done = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid) begin
            r = bresp;
            done = 1'b1;
         end
      end
   endtask

   // Read waits for the answer however long it takes
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic done;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid) begin
            d = rdata;
            r = rresp;
            done = 1'b1;
         end
      end
   endtask

   // Power-up clear of cause bits 0..6 before trusting irq
   task automatic clr_all(output logic [1:0] r);
      wr({nis_pkg::NIS_CAUSE_IDX, 2'b00}, 32'h0000_00ff, 4'hf, r);
   endtask
endmodule

`default_nettype wire

// >>> nis_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module nis_top_tb;
   localparam logic [7:0] A_CMD   = {nis_pkg::NIS_CMD_IDX, 2'b00};
   localparam logic [7:0] A_CAUSE = {nis_pkg::NIS_CAUSE_IDX, 2'b00};
   localparam logic [7:0] A_MASK  = {nis_pkg::NIS_MASK_IDX, 2'b00};
   // Event pattern beside the cause byte it should produce
   localparam logic [22:0] ROWS [13] = '{
      {15'h4000, 8'h01}, {15'h2000, 8'h02}, {15'h1000, 8'h04},
      {15'h0800, 8'h04}, {15'h0400, 8'h04}, {15'h0200, 8'h04},
      {15'h0100, 8'h08}, {15'h0080, 8'h08}, {15'h0040, 8'h10},
      {15'h0020, 8'h20}, {15'h0004, 8'h40}, {15'h0002, 8'h80},
      {15'h0001, 8'h00}};

   logic             aclk;
   logic             aresetn;
   logic [7:0]       awaddr;
   logic             awvalid;
   logic             awready;
   logic [31:0]      wdata;
   logic [3:0]       wstrb;
   logic             wvalid;
   logic             wready;
   logic [1:0]       bresp;
   logic             bvalid;
   logic [7:0]       araddr;
   logic             arvalid;
   logic             arready;
   logic [31:0]      rdata;
   logic [1:0]       rresp;
   logic             rvalid;
   nis_pkg::nis_ev_t ev;
   logic             frame_busy;
   logic             irq;
   logic             controller_offline;
   logic [31:0]      rdat;
   logic [1:0]       rsp;
   int               failures;
   int               tests_run;

   nis_top nis_top_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .ev(ev), .frame_busy(frame_busy),
      .irq(irq), .controller_offline(controller_offline));

   nis_host_model nis_host_model_inst (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid));

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      nis_host_model_inst.wr(a, {24'h0, d}, 4'hf, rsp);
   endtask

   task automatic rd(input logic [7:0] a);
      nis_host_model_inst.rd(a, rdat, rsp);
   endtask

   // One-cycle event, returns when the flag is visible
   task automatic pulse(input nis_pkg::nis_ev_t e);
      ev <= e;
      @(posedge aclk);
      ev <= '0;
      @(posedge aclk);
   endtask

   task automatic end_sim;
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // Whole run is a few hundred cycles, so this only cuts a hang
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      end_sim;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      failures = 0;
      tests_run = 0;
      aresetn = 1'b0;
      ev = '0;
      frame_busy = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(controller_offline, 1);
      rd(A_CAUSE); chk(rdat, 32'h80);
      rd(A_MASK); chk(rdat, 32'h00);
      nis_host_model_inst.clr_all(rsp);
      rd(A_CAUSE); chk(rdat, 32'h80);
      wr(A_CMD, 8'h02);
      rd(A_CAUSE); chk(rdat, 32'h00);
      chk(controller_offline, 0);
      rd(A_CMD); chk(rdat, 32'h02);
      // Masked flag is recorded but stays off the line
      pulse(15'h4000);
      chk(irq, 0);
      rd(A_CAUSE); chk(rdat, 32'h01);
      wr(A_MASK, 8'h03);
      chk(irq, 1);
      pulse(15'h2000);
      wr(A_CAUSE, 8'h01);
      rd(A_CAUSE); chk(rdat, 32'h02);
      chk(irq, 1);
      wr(A_CAUSE, 8'h00);
      rd(A_CAUSE); chk(rdat, 32'h02);
      rd(A_CAUSE); chk(rdat, 32'h02);
      wr(A_CAUSE, 8'h02);
      chk(irq, 0);
      // Every event source except tally_msb bits 1:0, all enabled
      wr(A_MASK, 8'h7f);
      for (int i = 0; i < 13; i++) begin
         pulse(ROWS[i][22:8]);
         chk(irq, {31'h0, |ROWS[i][6:0]});
         rd(A_CAUSE);
         chk(rdat, {24'h0, ROWS[i][7:0]});
         wr(A_CAUSE, 8'hff);
         rd(A_CAUSE); chk(rdat, {24'h0, ROWS[i][7:0] & 8'h80});
      end
      // Event lands on the edge that takes the clearing write
      fork
         begin
            ev <= 15'h4000;
            @(posedge aclk);
            ev <= '0;
         end
      join_none
      wr(A_CAUSE, 8'h01);
      rd(A_CAUSE); chk(rdat, 32'h01);
      wr(A_CAUSE, 8'h01);
      // Stop waits for the frame in progress
      frame_busy <= 1'b1;
      wr(A_CMD, 8'h01);
      repeat (4) @(posedge aclk);
      chk(controller_offline, 0);
      frame_busy <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(controller_offline, 1);
      rd(A_CAUSE); chk(rdat, 32'h80);
      chk(irq, 0);
      rd(A_CMD); chk(rdat, 32'h01);
      // Unmapped place and disabled byte lane
      rd(8'h10); chk(rsp, nis_pkg::NIS_RESP_SLVERR);
      chk(rdat, 32'h0);
      wr(8'h10, 8'hff); chk(rsp, nis_pkg::NIS_RESP_SLVERR);
      nis_host_model_inst.wr(A_MASK, 32'h0, 4'h0, rsp);
      chk(rsp, nis_pkg::NIS_RESP_OKAY);
      rd(A_MASK); chk(rdat, 32'h7f);
      // Second reset in mid-run
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(controller_offline, 1);
      chk(irq, 0);
      rd(A_MASK); chk(rdat, 32'h00);
      end_sim;
   end
endmodule

`default_nettype wire
